// *** pkg/cks_pkg.sv ***
// Shared constants and state encodings for the clock switch controller
package cks_pkg;
  // Register byte addresses
  localparam logic [1:0] ADDR_CTRL_LO = 2'h0;
  localparam logic [1:0] ADDR_CTRL_HI = 2'h1;
  localparam logic [1:0] ADDR_CLK_DIV = 2'h2;
  localparam logic [1:0] ADDR_STATUS  = 2'h3;

  // Unlock keys for the two control bytes
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9a;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;

  // Low control byte field positions
  localparam int BIT_REQ        = 0;
  localparam int BIT_SECONDARY_OSC_EN    = 1;
  localparam int BIT_PRIMARY_OSC_SLEEP = 2;
  localparam int BIT_CFAIL      = 3;
  localparam int BIT_CLK_LOCK   = 7;
  // Clock divider byte field position
  localparam int SYSTEM_BRANCH_DIV_SEL_MSB      = 7;

  // Three-bit source codes
  localparam logic [2:0] SRC_FRC     = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI     = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC     = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSC    = 3'h5;
  localparam logic [2:0] SRC_RSVD    = 3'h6;
  localparam logic [2:0] SRC_FRC_DIV = 3'h7;

  // Oscillator indices for run enables and clock gates
  localparam logic [1:0] OSC_FRC  = 2'h0;
  localparam logic [1:0] OSC_PRI  = 2'h1;
  localparam logic [1:0] OSC_SEC  = 2'h2;
  localparam logic [1:0] OSC_LOW_POWER_RC_OSC = 2'h3;

  // Timing and divider figures
  localparam logic [3:0] SWITCH_WAIT_CYCLES = 4'ha;
  localparam logic [1:0] USB_BRANCH_DIV     = 2'h2;
  localparam logic [4:0] SYS_BASE_DIV       = 5'h3;
  localparam logic [1:0] RST_SYSTEM_BRANCH_DIV_SEL          = 2'h0;

  typedef enum logic [2:0] {
    U_IDLE  = 3'b000,
    U_H1    = 3'b001,
    U_HOPEN = 3'b010,
    U_L1    = 3'b011,
    U_LOPEN = 3'b100
  } cks_unlock_t;

  typedef enum logic [2:0] {
    S_IDLE      = 3'b000,
    S_CHECK     = 3'b001,
    S_WAIT_RDY  = 3'b010,
    S_WAIT_LOCK = 3'b011,
    S_COUNT     = 3'b100,
    S_GATE_OFF  = 3'b101
  } cks_sw_t;
endpackage

// *** hw/cks_clock_switch.sv ***
// Clock source switch controller with unlock sequences and USB PLL divider setup
// Summary of operation
// - Switching and monitor enabled only when config zero
// - Disabled: current source follows initial config
// - Disabled: switch request ignored, reads zero
// - High byte write needs 78h then 9Ah
// - Low byte write needs 46h then 57h
// - Equal current and new source aborts switch
// - Valid switch clears lock status and fail flag
// - Start new source, wait start-up ready
// - PLL sources wait for lock before continuing
// - Count ten new-clock edges before changeover
// - Done: clear request, copy new to current
// - Stop old source except kept LOW_POWER_RC_OSC, secondary
// - Primary submode fixed by configuration only
// - Processor keeps running during switch sequence
// - USB enabled gives continuous 48 MHz clock; code enables it only with lock status set (locked PLL source)
// - Prescaler makes 4 MHz for 96 MHz PLL
// - USB branch divides two, system three times two to the power of select
// - Prescale division from three-bit config field
// - Three-bit source code assignments
// - Monitor plus lock bit freezes clock selection
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module cks_clock_switch (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       switch_enable_cfg,
  input  wire logic [2:0] initial_source_cfg,
  input  wire logic [1:0] primary_submode_cfg,
  input  wire logic [2:0] usb_prescale_cfg,
  input  wire logic       wdt_enable,
  input  wire logic       usb_enable,
  input  wire logic [3:0] osc_clk_in,
  input  wire logic [3:0] osc_ready_in,
  input  wire logic       pll_lock_in,
  input  wire logic       clock_fail_in,
  output logic      [3:0] osc_run_en,
  output logic      [1:0] primary_submode,
  output logic            pll_en,
  output logic      [3:0] sys_clk_gate,
  output logic      [2:0] sys_src_sel,
  output logic      [3:0] pll_prescale_div,
  output logic      [4:0] sys_branch_div,
  output logic      [1:0] usb_branch_div,
  output logic            usb_clk_en,
  output logic            failsafe_clock_monitor
);

  typedef struct packed {
    cks_pkg::cks_unlock_t useq;
    cks_pkg::cks_sw_t     sst;
    logic [2:0]           cur;
    logic [2:0]           nsel;
    logic                 req;
    logic                 clock_select_lock;
    logic                 lock_stat;
    logic                 cf;
    logic                 primary_osc_sleep;
    logic                 secondary_osc_en;
    logic [1:0]           system_branch_div_sel;
    logic [3:0]           run_en;
    logic [3:0]           osc_en;
    logic [3:0]           gate;
    logic                 pll_en;
    logic                 usb_clk_en;
    logic [3:0]           pre_div;
    logic [4:0]           sys_div;
    logic [3:0]           cnt;
    logic [9:0]           s1;
    logic [9:0]           s2;
    logic [3:0]           clk_prev;
    logic [7:0]           rdata;
  } cks_state_t;

  cks_state_t q;
  cks_state_t n;
  cks_state_t rst;

  // Map a source code onto the oscillator that feeds it
  function automatic logic [1:0] osc_of(input logic [2:0] code);
    case (code)
      cks_pkg::SRC_PRI, cks_pkg::SRC_PRI_PLL: osc_of = cks_pkg::OSC_PRI;
      cks_pkg::SRC_SEC:                        osc_of = cks_pkg::OSC_SEC;
      cks_pkg::SRC_LOW_POWER_RC_OSC:                       osc_of = cks_pkg::OSC_LOW_POWER_RC_OSC;
      default:                                 osc_of = cks_pkg::OSC_FRC;
    endcase
  endfunction

  // Sources that run through the PLL
  function automatic logic uses_pll(input logic [2:0] code);
    uses_pll = (code == cks_pkg::SRC_PRI_PLL) || (code == cks_pkg::SRC_FRC_PLL);
  endfunction

  // Prescaler division; the input frequency is never sensed
  function automatic logic [3:0] prescale(input logic [2:0] sel);
    case (sel)
      3'h0:    prescale = 4'h1;
      3'h1:    prescale = 4'h2;
      3'h2:    prescale = 4'h3;
      3'h3:    prescale = 4'h4;
      3'h4:    prescale = 4'h5;
      3'h5:    prescale = 4'h6;
      3'h6:    prescale = 4'ha;
      default: prescale = 4'hc;
    endcase
  endfunction

  logic       sw_allow;
  logic       locked;
  logic [1:0] new_osc;
  logic [1:0] cur_osc;
  logic [3:0] rdy;
  logic       new_edge;
  logic       wr_hi_ok;
  logic       wr_lo_ok;

  // Decode terms; the monitor is on exactly when switching is on
  always_comb begin
    sw_allow = ~switch_enable_cfg;
    locked   = sw_allow & q.clock_select_lock;
    new_osc  = osc_of(q.nsel);
    cur_osc  = osc_of(q.cur);
    rdy      = q.s2[7:4];
    new_edge = q.s2[new_osc] & ~q.clk_prev[new_osc];
    wr_hi_ok = reg_wr && (reg_addr == cks_pkg::ADDR_CTRL_HI) && (q.useq == cks_pkg::U_HOPEN);
    wr_lo_ok = reg_wr && (reg_addr == cks_pkg::ADDR_CTRL_LO) && (q.useq == cks_pkg::U_LOPEN);
  end

  // Reset image: the selection starts from the initial-source straps
  always_comb begin
    rst            = '0;
    rst.useq       = cks_pkg::U_IDLE;
    rst.sst        = cks_pkg::S_IDLE;
    rst.cur        = initial_source_cfg;
    rst.nsel       = initial_source_cfg;
    rst.system_branch_div_sel      = cks_pkg::RST_SYSTEM_BRANCH_DIV_SEL;
    rst.run_en     = 4'h1 << osc_of(initial_source_cfg);
    rst.osc_en     = 4'h1 << osc_of(initial_source_cfg);
    rst.gate       = 4'h1 << osc_of(initial_source_cfg);
    rst.pll_en     = uses_pll(initial_source_cfg);
    rst.pre_div    = prescale(usb_prescale_cfg);
    rst.sys_div    = cks_pkg::SYS_BASE_DIV;
  end

  // Next-state logic for the whole block
  always_comb begin
    n          = q;
    // Async status inputs pass two flops; only s2 is read by logic
    n.s1       = {clock_fail_in, pll_lock_in, osc_ready_in, osc_clk_in};
    n.s2       = q.s1;
    n.clk_prev = q.s2[3:0];
    n.rdata    = 8'h00;

    // Unlock sequencer: any write either advances it or drops it
    if (reg_wr) begin
      case (q.useq)
        cks_pkg::U_IDLE: begin
          if (reg_addr == cks_pkg::ADDR_CTRL_HI && reg_wdata == cks_pkg::KEY_HI_1) begin
            n.useq = cks_pkg::U_H1;
          end else if (reg_addr == cks_pkg::ADDR_CTRL_LO && reg_wdata == cks_pkg::KEY_LO_1) begin
            n.useq = cks_pkg::U_L1;
          end
        end
        cks_pkg::U_H1: begin
          n.useq = (reg_addr == cks_pkg::ADDR_CTRL_HI && reg_wdata == cks_pkg::KEY_HI_2)
                   ? cks_pkg::U_HOPEN : cks_pkg::U_IDLE;
        end
        cks_pkg::U_L1: begin
          n.useq = (reg_addr == cks_pkg::ADDR_CTRL_LO && reg_wdata == cks_pkg::KEY_LO_2)
                   ? cks_pkg::U_LOPEN : cks_pkg::U_IDLE;
        end
        default: n.useq = cks_pkg::U_IDLE;
      endcase
    end

    // High byte: only the new-source field is writable
    if (wr_hi_ok && !locked) begin
      n.nsel = reg_wdata[2:0];
    end

    // Low byte: set-only lock, clear-only fail flag, request start
    if (wr_lo_ok) begin
      n.secondary_osc_en    = reg_wdata[cks_pkg::BIT_SECONDARY_OSC_EN];
      n.primary_osc_sleep = reg_wdata[cks_pkg::BIT_PRIMARY_OSC_SLEEP];
      if (reg_wdata[cks_pkg::BIT_CLK_LOCK]) begin
        n.clock_select_lock = 1'b1;
      end
      if (!reg_wdata[cks_pkg::BIT_CFAIL]) begin
        n.cf = 1'b0;
      end
      if (reg_wdata[cks_pkg::BIT_REQ] && sw_allow && !locked && q.sst == cks_pkg::S_IDLE) begin
        n.req = 1'b1;
        n.sst = cks_pkg::S_CHECK;
      end
    end

    // Divider select needs no unlock; slow settings refused under USB
    if (reg_wr && reg_addr == cks_pkg::ADDR_CLK_DIV) begin
      if (!(usb_enable && reg_wdata[cks_pkg::SYSTEM_BRANCH_DIV_SEL_MSB])) begin
        n.system_branch_div_sel = reg_wdata[cks_pkg::SYSTEM_BRANCH_DIV_SEL_MSB -: 2];
      end
    end

    // Switch sequencer; the CPU is never stalled while it runs
    case (q.sst)
      cks_pkg::S_IDLE: begin
        n.lock_stat = uses_pll(q.cur) & q.s2[8];
      end
      cks_pkg::S_CHECK: begin
        if (q.nsel == q.cur || q.nsel == cks_pkg::SRC_RSVD) begin
          n.req = 1'b0;
          n.sst = cks_pkg::S_IDLE;
        end else begin
          n.lock_stat       = 1'b0;
          n.cf              = 1'b0;
          n.run_en[new_osc] = 1'b1;
          n.sst             = cks_pkg::S_WAIT_RDY;
        end
      end
      cks_pkg::S_WAIT_RDY: begin
        if (rdy[new_osc]) begin
          n.cnt = 4'h0;
          if (uses_pll(q.nsel)) begin
            n.pll_en = 1'b1;
            n.sst    = cks_pkg::S_WAIT_LOCK;
          end else begin
            n.sst = cks_pkg::S_COUNT;
          end
        end
      end
      cks_pkg::S_WAIT_LOCK: begin
        if (q.s2[8]) begin
          n.lock_stat = 1'b1;
          n.sst       = cks_pkg::S_COUNT;
        end
      end
      cks_pkg::S_COUNT: begin
        if (new_edge) begin
          if (q.cnt == cks_pkg::SWITCH_WAIT_CYCLES - 4'h1) begin
            n.gate = 4'h0;
            n.sst  = cks_pkg::S_GATE_OFF;
          end else begin
            n.cnt = q.cnt + 4'h1;
          end
        end
      end
      cks_pkg::S_GATE_OFF: begin
        // All gates closed for one cycle before the new one opens
        n.gate = 4'h1 << new_osc;
        n.cur  = q.nsel;
        n.req  = 1'b0;
        if (cur_osc != new_osc) begin
          n.run_en[cur_osc] = 1'b0;
        end
        if (!uses_pll(q.nsel)) begin
          n.pll_en = 1'b0;
        end
        n.sst = cks_pkg::S_IDLE;
      end
      default: n.sst = cks_pkg::S_IDLE;
    endcase

    // Disabled switching: selection pinned to straps, request held low
    if (!sw_allow) begin
      n.cur  = initial_source_cfg;
      n.req  = 1'b0;
      n.sst  = cks_pkg::S_IDLE;
    end

    // Fail flag set after all clears so a coincident event wins
    if (sw_allow && q.s2[9]) begin
      n.cf = 1'b1;
    end

    // Kept-alive oscillators ride on top of the switch-driven enables
    n.osc_en = n.run_en;
    if (n.secondary_osc_en) begin
      n.osc_en[cks_pkg::OSC_SEC] = 1'b1;
    end
    if (wdt_enable || sw_allow) begin
      n.osc_en[cks_pkg::OSC_LOW_POWER_RC_OSC] = 1'b1;
    end

    // PLL branch figures and USB clock availability
    n.pre_div    = prescale(usb_prescale_cfg);
    n.sys_div    = 5'(cks_pkg::SYS_BASE_DIV << n.system_branch_div_sel);
    n.usb_clk_en = usb_enable & q.lock_stat;

    // Read port; data appear the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        cks_pkg::ADDR_CTRL_LO: n.rdata = {q.clock_select_lock, 1'b0, q.lock_stat, 1'b0,
                                          q.cf, q.primary_osc_sleep, q.secondary_osc_en, q.req};
        cks_pkg::ADDR_CTRL_HI: n.rdata = {1'b0, q.cur, 1'b0, q.nsel};
        cks_pkg::ADDR_CLK_DIV: n.rdata = {q.system_branch_div_sel, 6'h00};
        default:               n.rdata = {q.sst, q.pll_en, q.osc_en};
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= rst;
    end else begin
      q <= n;
    end
  end

  // Outputs from flops except strap-fed submode and monitor and the fixed USB divider; submode is never switched
  assign reg_rdata              = q.rdata;
  assign osc_run_en             = q.osc_en;
  assign primary_submode        = primary_submode_cfg;
  assign pll_en                 = q.pll_en;
  assign sys_clk_gate           = q.gate;
  assign sys_src_sel            = q.cur;
  assign pll_prescale_div       = q.pre_div;
  assign sys_branch_div         = q.sys_div;
  assign usb_branch_div         = cks_pkg::USB_BRANCH_DIV;
  assign usb_clk_en             = q.usb_clk_en;
  assign failsafe_clock_monitor = sw_allow;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_DIS_REQ_ZERO: assert property (switch_enable_cfg |=> !q.req)
    else $error("request bit set while switching disabled");
  AST_DIS_CUR_CFG: assert property (switch_enable_cfg |=> q.cur == $past(initial_source_cfg))
    else $error("current source not following straps");
  AST_REDUNDANT: assert property ((q.sst == cks_pkg::S_CHECK && q.nsel == q.cur)
    |=> !q.req && q.sst == cks_pkg::S_IDLE)
    else $error("redundant switch not aborted");
  AST_CLEAR_LOCK: assert property ((q.sst == cks_pkg::S_CHECK && q.nsel != q.cur
    && q.nsel != cks_pkg::SRC_RSVD && !switch_enable_cfg) |=> !q.lock_stat)
    else $error("lock status not cleared on valid switch");
  AST_WAIT_LOCK: assert property ((q.sst == cks_pkg::S_WAIT_LOCK && !q.s2[8] && !switch_enable_cfg)
    |=> q.sst == cks_pkg::S_WAIT_LOCK)
    else $error("left lock wait without lock");
  AST_TEN_EDGES: assert property ($rose(q.sst == cks_pkg::S_GATE_OFF)
    |-> $past(q.cnt) == 4'h9 && $past(new_edge))
    else $error("changeover before ten new-clock edges");
  AST_DONE: assert property ((q.sst == cks_pkg::S_GATE_OFF && !switch_enable_cfg)
    |=> !q.req && q.cur == $past(q.nsel) && sys_clk_gate == (4'h1 << $past(new_osc)))
    else $error("completion did not update selection");
  AST_BREAK_MAKE: assert property (q.sst == cks_pkg::S_GATE_OFF
    |-> sys_clk_gate == 4'h0 && $past(sys_clk_gate) != 4'h0)
    else $error("clock gates not all closed at changeover");
  AST_ONE_GATE: assert property ($countones(sys_clk_gate) <= 1)
    else $error("more than one clock gate open");
  AST_HI_LOCKED: assert property ((reg_wr && reg_addr == cks_pkg::ADDR_CTRL_HI
    && q.useq != cks_pkg::U_HOPEN) |=> q.nsel == $past(q.nsel))
    else $error("high byte written without unlock");
  AST_LOW_POWER_RC_OSC_KEPT: assert property (wdt_enable ##1 wdt_enable |-> osc_run_en[cks_pkg::OSC_LOW_POWER_RC_OSC])
    else $error("low-power RC stopped while watchdog enabled");
  AST_USB_CLK: assert property ((usb_enable && q.lock_stat) |=> usb_clk_en)
    else $error("USB clock not enabled");
  // Slow system-branch settings would starve the USB side, so they must not land
  AST_DIV_GUARD: assert property ((reg_wr && usb_enable && reg_wdata[cks_pkg::SYSTEM_BRANCH_DIV_SEL_MSB]
    && reg_addr == cks_pkg::ADDR_CLK_DIV) |=> q.system_branch_div_sel == $past(q.system_branch_div_sel))
    else $error("divider slowed while USB enabled");
  AST_RSVD_ABORT: assert property ((q.nsel == cks_pkg::SRC_RSVD
    && q.sst == cks_pkg::S_CHECK) |=> !q.req && q.sst == cks_pkg::S_IDLE)
    else $error("reserved source not refused");

endmodule

// *** bench/tb_cks_clock_switch.sv ***
// Self-checking bench for the clock switch controller
module tb_cks_clock_switch;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk;
  logic       reset;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       switch_enable_cfg;
  logic [2:0] initial_source_cfg;
  logic [1:0] primary_submode_cfg;
  logic [2:0] usb_prescale_cfg;
  logic       wdt_enable;
  logic       usb_enable;
  logic [3:0] osc_clk_in;
  logic [3:0] osc_ready_in;
  logic       pll_lock_in;
  logic       clock_fail_in;
  logic [3:0] osc_run_en;
  logic [1:0] primary_submode;
  logic       pll_en;
  logic [3:0] sys_clk_gate;
  logic [2:0] sys_src_sel;
  logic [3:0] pll_prescale_div;
  logic [4:0] sys_branch_div;
  logic [1:0] usb_branch_div;
  logic       usb_clk_en;
  logic       failsafe_clock_monitor;
  int         err_total;
  int         n_compared;
  int         cyc;
  logic       gz;
  logic [7:0] v;
  logic [3:0] pdiv [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'ha, 4'hc};

  cks_clock_switch u_cks_clock_switch (.*);

  // Free-running system clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Oscillator inputs toggle every system cycle; the design resynchronises them
  always @(posedge clk) begin
    osc_clk_in <= ~osc_clk_in;
  end

  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  // Bus write: strobe stays up so writes can run back to back
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    reg_rd    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask

  task automatic unlock_hi(input logic [2:0] s);
    wr(2'h1, cks_pkg::KEY_HI_1);
    wr(2'h1, cks_pkg::KEY_HI_2);
    wr(2'h1, {5'h00, s});
    idle(1);
  endtask

  task automatic unlock_lo(input logic [7:0] d);
    wr(2'h0, cks_pkg::KEY_LO_1);
    wr(2'h0, cks_pkg::KEY_LO_2);
    wr(2'h0, d);
    idle(1);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  // Bounded wait for a changeover, noting whether all gates closed on the way
  task automatic wait_src(input logic [2:0] s);
    gz = 1'b0;
    for (cyc = 0; cyc < 300 && sys_src_sel !== s; cyc++) begin
      @(posedge clk);
      #1;
      if (sys_clk_gate === 4'h0) gz = 1'b1;
    end
    if (cyc >= 300) begin
      $display("mismatch changeover expected %h seen %h", s, sys_src_sel);
      err_total++;
      give_verdict();
    end
  endtask

  initial begin
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    switch_enable_cfg = 1'b1;
    initial_source_cfg = cks_pkg::SRC_FRC;
    primary_submode_cfg = 2'h2;
    usb_prescale_cfg = 3'h0;
    wdt_enable = 1'b0;
    usb_enable = 1'b0;
    osc_clk_in = 4'h0;
    osc_ready_in = 4'h9;
    pll_lock_in = 1'b0;
    clock_fail_in = 1'b0;
    // Switching disabled: selection writes and requests leave the current source unchanged
    do_reset();
    chk("monitor", 8'h00, {7'h00, failsafe_clock_monitor});
    chk("submode", 8'h02, {6'h00, primary_submode});
    unlock_hi(cks_pkg::SRC_PRI);
    unlock_lo(8'h01);
    rd(2'h0, v);
    chk("req disabled", 8'h00, {7'h00, v[0]});
    rd(2'h1, v);
    idle(30);
    chk("current disabled", 8'h00, {5'h00, v[6:4]});
    chk("src disabled", 8'h00, {5'h00, sys_src_sel});
    // Watchdog alone must keep the low-power RC alive
    wdt_enable <= 1'b1;
    idle(2);
    chk("low_power_rc_osc kept", 8'h01, {7'h00, osc_run_en[3]});
    wdt_enable <= 1'b0;
    // Enabled from here on
    switch_enable_cfg <= 1'b0;
    do_reset();
    chk("monitor", 8'h01, {7'h00, failsafe_clock_monitor});
    // Foreign write between keys cancels the unlock
    wr(2'h1, cks_pkg::KEY_HI_1);
    wr(2'h2, 8'h00);
    wr(2'h1, cks_pkg::KEY_HI_2);
    wr(2'h1, 8'h02);
    idle(1);
    rd(2'h1, v);
    chk("hi cancelled", 8'h00, v);
    // Redundant request clears itself and changes nothing
    unlock_lo(8'h01);
    idle(2);
    rd(2'h0, v);
    chk("redundant req", 8'h00, v);
    // Reserved source code is refused like a redundant one
    unlock_hi(cks_pkg::SRC_RSVD);
    unlock_lo(8'h01);
    idle(2);
    rd(2'h0, v);
    chk("reserved req", 8'h00, v);
    // Unlock opens exactly one write
    wr(2'h1, cks_pkg::KEY_HI_1);
    wr(2'h1, cks_pkg::KEY_HI_2);
    wr(2'h1, {5'h00, cks_pkg::SRC_PRI});
    wr(2'h1, 8'h04);
    idle(1);
    rd(2'h1, v);
    chk("new after window", 8'h02, v);
    // Switch to primary: held until the oscillator reports ready
    unlock_lo(8'h01);
    idle(30);
    rd(2'h0, v);
    chk("req waiting", 8'h01, {7'h00, v[0]});
    chk("primary powered", 8'h01, {7'h00, osc_run_en[1]});
    chk("src waiting", 8'h00, {5'h00, sys_src_sel});
    osc_ready_in <= 4'hb;
    wait_src(cks_pkg::SRC_PRI);
    // Ready seen 3 edges on, then 10 edges two cycles apart, then one gated cycle
    chk("ten edges", 8'h01, {7'h00, cyc inside {23, 24}});
    chk("gates closed", 8'h01, {7'h00, gz});
    idle(1);
    rd(2'h1, v);
    chk("hi after switch", 8'h22, v);
    rd(2'h0, v);
    chk("req done", 8'h00, {7'h00, v[0]});
    chk("run enables", 8'h0a, {4'h0, osc_run_en});
    chk("gate one-hot", 8'h02, {4'h0, sys_clk_gate});
    // Fail flag set by monitor, cleared when a valid switch starts
    clock_fail_in <= 1'b1;
    idle(4);
    rd(2'h0, v);
    chk("fail flag", 8'h08, v);
    clock_fail_in <= 1'b0;
    unlock_hi(cks_pkg::SRC_PRI_PLL);
    // Fail bit written as one so only the hardware can clear it
    unlock_lo(8'h09);
    idle(40);
    rd(2'h0, v);
    chk("lock wait", 8'h01, v);
    chk("pll powered", 8'h01, {7'h00, pll_en});
    chk("src lock wait", 8'h02, {5'h00, sys_src_sel});
    pll_lock_in <= 1'b1;
    usb_enable <= 1'b1;
    wait_src(cks_pkg::SRC_PRI_PLL);
    idle(4);
    rd(2'h0, v);
    chk("lock stat", 8'h20, v);
    chk("usb clock", 8'h01, {7'h00, usb_clk_en});
    chk("usb div", 8'h02, {6'h00, usb_branch_div});
    // Prescaler follows the three-bit field
    for (int i = 0; i < 8; i++) begin
      usb_prescale_cfg <= 3'(i);
      idle(3);
      chk("prescale", {4'h0, pdiv[i]}, {4'h0, pll_prescale_div});
    end
    // System branch divider for every select, USB off for the slow ones
    usb_enable <= 1'b0;
    for (int i = 3; i >= 0; i--) begin
      wr(2'h2, {2'(i), 6'h00});
      idle(2);
      chk("sys div", 8'(3 << i), {3'h0, sys_branch_div});
    end
    usb_enable <= 1'b1;
    wr(2'h2, 8'h40);
    wr(2'h2, 8'h80);
    idle(1);
    rd(2'h2, v);
    chk("div usb guard", 8'h40, v);
    // Lock bit with monitor on freezes the selection
    unlock_lo(8'h80);
    unlock_hi(cks_pkg::SRC_FRC);
    rd(2'h1, v);
    chk("locked select", 8'h33, v);
    // Status: idle sequencer, PLL on, primary plus kept low-power RC
    rd(2'h3, v);
    chk("status", 8'h1a, v);
    give_verdict();
  end
endmodule
